// *** rcr_pkg.sv ***
// Purpose: Shared constants for the reset cause recorder
// Assumes: 20 MHz pclk, APB register bus with 8-bit byte addresses
// Notes: Offsets are byte addresses of aligned 32-bit words
package rcr_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_CAUSE = 8'h00;
	localparam logic [7:0] OFF_CTL = 8'h04;
	localparam logic [7:0] OFF_CTL_SET = 8'h08;
	localparam logic [7:0] OFF_CTL_CLR = 8'h0c;
	localparam logic [7:0] OFF_LVL = 8'h10;
	localparam logic [7:0] OFF_IRQF = 8'h14;
	localparam logic [7:0] OFF_MASK = 8'h18;
	localparam logic [7:0] OFF_EDGE = 8'h1c;

	// Field positions
	localparam int CAUSE_LVD_BIT = 0;
	localparam int CAUSE_WDT_BIT = 1;
	localparam int CTL_ON_BIT = 7;
	localparam int CTL_MODE_BIT = 1;
	localparam int CTL_FLAG_BIT = 0;
	localparam int IRQ_LVD_LOW_BIT = 0;
	localparam int IRQ_LVD_OK_BIT = 1;

	// Values after reset
	localparam logic [1:0] CAUSE_RST = 2'h0;
	localparam logic [3:0] LVL_RST = 4'h0;
	localparam logic [7:0] IRQF_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] EDGE_RST = 8'h00;
	localparam logic [2:0] SYNC_RST = 3'h2;

	// Highest legal detection level code, ten levels 0..9
	localparam logic [3:0] LVL_MAX = 4'h9;

	// Stabilisation wait after a reset source goes away
	localparam int CLK_MHZ = 20;
	localparam int STAB_NS = 2000;
	localparam logic [5:0] STAB_CYC = 6'((STAB_NS * CLK_MHZ + 999) / 1000);

	typedef enum logic [1:0] {RCR_RUN, RCR_HOLD, RCR_STAB} rcr_phase_e;

endpackage : rcr_pkg

// *** rcr_sync.sv ***
// Purpose: Two-stage synchroniser for asynchronous level inputs
// Assumes: Inputs are slow levels, no pulses shorter than two cycles
// Notes: Stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none
module rcr_sync #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// One pair of flops per bit
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else if (ce) begin
					meta <= d[i];
					q[i] <= meta;
				end
			end
		end
	endgenerate

endmodule : rcr_sync
`default_nettype wire

// *** rcr_top.sv ***
// Purpose: Reset cause recording, reset sequencing, low-voltage control
// Assumes: presetn is the true power-up reset; comparators are async
// Notes: Internal resets never touch the cause flags except as sourced
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - Pin or power-on-clear reset clears whole cause register to zero.
// - Reading the cause register returns contents, then clears it.
// - Watchdog or low-voltage reset sets its own flag, keeps the other.
// - Low-voltage reset flag sits at bit zero of the cause register.
// - A flag reads one only after its source requested a reset.
// - Pin, power-on and watchdog resets clear detector setup; its own keeps it.
// - Detector control accepts bit-wise and whole writes; pin, power-on and watchdog resets clear it.
// - Power-on-clear holds reset at power-up and while supply is low.
// - Supply below level raises interrupt or reset, per mode bit.
// - Ten selectable detection levels through the level-select register.
// - Detector keeps working in clock-stopped standby.
// - During reset and stabilisation other hardware keeps its state.
// - Reset-established state is kept unchanged while in standby.
// - Any reset clears request flags and edge modes, sets all masks.
module rcr_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_reset_n,
	input wire logic poc_below,
	input wire logic lvd_below,
	input wire logic wdt_overflow,
	input wire logic standby,
	output logic sys_reset,
	output logic lvd_enable,
	output logic [3:0] lvd_level,
	output logic irq
);

	typedef struct packed {
		rcr_pkg::rcr_phase_e phase;
		logic [5:0] stab;
		logic [1:0] cause;
		logic lv_on;
		logic lv_mode;
		logic [3:0] lvl;
		logic [7:0] irqf;
		logic [7:0] mask;
		logic [7:0] edge_mode;
		logic lv_low_d;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic [1:0] rd_snap;
		logic sys_rst;
		logic irq_o;
	} rcr_state_s;

	rcr_state_s r;
	rcr_state_s next_r;
	logic [2:0] sync_q;
	logic pin_n_s;
	logic poc_s;
	logic lv_s;
	logic hard_rst;
	logic wdt_rst;
	logic lvd_rst;
	logic any_src;
	logic lv_flag;
	logic bus_ok;
	logic setup;
	logic done;

	// Pin and comparator levels come from outside the clock domain
	rcr_sync #(
		.W(3),
		.RST_VAL(rcr_pkg::SYNC_RST)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d({lvd_below, poc_below, pin_reset_n}),
		.q(sync_q)
	);

	// Reset sources, detector runs regardless of standby
	assign pin_n_s = sync_q[0];
	assign poc_s = sync_q[1];
	assign lv_s = sync_q[2];
	assign hard_rst = ~pin_n_s | poc_s;
	assign wdt_rst = wdt_overflow;
	assign lvd_rst = lv_s & r.lv_on & r.lv_mode;
	assign any_src = hard_rst | wdt_rst | lvd_rst;
	assign lv_flag = lv_s & r.lv_on;

	// CPU side is quiet in reset and in standby
	assign bus_ok = ~r.sys_rst & ~standby;
	assign setup = psel & ~penable;
	assign done = psel & penable & r.rdy;

	// Next-state logic
	always_comb begin
		logic [31:0] rv;
		logic hit;
		rv = 32'h0000_0000;
		hit = 1'b1;
		next_r = r;

		// Read mux, cause shown as a whole word
		case (paddr)
			rcr_pkg::OFF_CAUSE: rv = {30'h0, r.cause};
			rcr_pkg::OFF_CTL,
			rcr_pkg::OFF_CTL_SET,
			rcr_pkg::OFF_CTL_CLR: begin
				rv[rcr_pkg::CTL_ON_BIT] = r.lv_on;
				rv[rcr_pkg::CTL_MODE_BIT] = r.lv_mode;
				rv[rcr_pkg::CTL_FLAG_BIT] = lv_flag;
			end
			rcr_pkg::OFF_LVL: rv = {28'h0, r.lvl};
			rcr_pkg::OFF_IRQF: rv = {24'h0, r.irqf};
			rcr_pkg::OFF_MASK: rv = {24'h0, r.mask};
			rcr_pkg::OFF_EDGE: rv = {24'h0, r.edge_mode};
			default: hit = 1'b0;
		endcase

		// Setup cycle prepares the answer for the access cycle
		next_r.rdy = 1'b0;
		if (setup) begin
			next_r.rdy = 1'b1;
			next_r.err = ~hit;
			next_r.rdata = pwrite ? 32'h0000_0000 : rv;
			next_r.rd_snap = 2'h0;
			if (!pwrite && paddr == rcr_pkg::OFF_CAUSE) begin
				next_r.rd_snap = r.cause;
			end
		end

		// Access cycle commits writes and the read side effect
		if (done && bus_ok && !r.err) begin
			if (pwrite) begin
				case (paddr)
					rcr_pkg::OFF_CTL: begin
						next_r.lv_on = pwdata[rcr_pkg::CTL_ON_BIT];
						next_r.lv_mode = pwdata[rcr_pkg::CTL_MODE_BIT];
					end
					rcr_pkg::OFF_CTL_SET: begin
						next_r.lv_on = r.lv_on | pwdata[rcr_pkg::CTL_ON_BIT];
						next_r.lv_mode = r.lv_mode | pwdata[rcr_pkg::CTL_MODE_BIT];
					end
					rcr_pkg::OFF_CTL_CLR: begin
						next_r.lv_on = r.lv_on & ~pwdata[rcr_pkg::CTL_ON_BIT];
						next_r.lv_mode = r.lv_mode & ~pwdata[rcr_pkg::CTL_MODE_BIT];
					end
					rcr_pkg::OFF_LVL: begin
						// Codes above nine are prohibited and dropped
						if (pwdata[3:0] <= rcr_pkg::LVL_MAX) begin
							next_r.lvl = pwdata[3:0];
						end
					end
					rcr_pkg::OFF_IRQF: next_r.irqf = r.irqf & ~pwdata[7:0];
					rcr_pkg::OFF_MASK: next_r.mask = pwdata[7:0];
					rcr_pkg::OFF_EDGE: next_r.edge_mode = pwdata[7:0];
					default: ;
				endcase
			end else begin
				// Only the bits shown are cleared, a late set survives
				next_r.cause = r.cause & ~r.rd_snap;
			end
		end

		// Detector events, placed after the clear so a set wins
		next_r.lv_low_d = lv_flag;
		if (lv_flag && !r.lv_low_d && !r.lv_mode) begin
			next_r.irqf[rcr_pkg::IRQ_LVD_LOW_BIT] = 1'b1;
		end
		if (!lv_flag && r.lv_low_d) begin
			next_r.irqf[rcr_pkg::IRQ_LVD_OK_BIT] = 1'b1;
		end

		// Reset phase sequencing
		case (r.phase)
			rcr_pkg::RCR_RUN: ;
			rcr_pkg::RCR_HOLD: begin
				if (!any_src) begin
					next_r.phase = rcr_pkg::RCR_STAB;
					next_r.stab = 6'h00;
				end
			end
			rcr_pkg::RCR_STAB: begin
				if (r.stab == rcr_pkg::STAB_CYC - 6'h01) begin
					next_r.phase = rcr_pkg::RCR_RUN;
				end else begin
					next_r.stab = r.stab + 6'h01;
				end
			end
			default: next_r.phase = rcr_pkg::RCR_RUN;
		endcase

		// Source-dependent effects of an internal reset, applied in every
		// cycle a source is active; in stabilisation the state is only held
		if (any_src) begin
			next_r.phase = rcr_pkg::RCR_HOLD;
			next_r.stab = 6'h00;
			next_r.irqf = rcr_pkg::IRQF_RST;
			next_r.mask = rcr_pkg::MASK_RST;
			next_r.edge_mode = rcr_pkg::EDGE_RST;
			next_r.rdy = 1'b0;
		end
		if (hard_rst) begin
			next_r.cause = rcr_pkg::CAUSE_RST;
		end else begin
			if (wdt_rst) begin
				next_r.cause[rcr_pkg::CAUSE_WDT_BIT] = 1'b1;
			end
			if (lvd_rst) begin
				next_r.cause[rcr_pkg::CAUSE_LVD_BIT] = 1'b1;
			end
		end
		// The detector's own reset leaves its setup alone
		if (hard_rst || wdt_rst) begin
			next_r.lv_on = 1'b0;
			next_r.lv_mode = 1'b0;
			next_r.lvl = rcr_pkg::LVL_RST;
		end

		next_r.sys_rst = next_r.phase != rcr_pkg::RCR_RUN;
		next_r.irq_o = |(next_r.irqf & ~next_r.mask);
	end

	// Power-up reset starts in hold, like a power-on-clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.phase <= rcr_pkg::RCR_HOLD;
			r.mask <= rcr_pkg::MASK_RST;
			r.sys_rst <= 1'b1;
		end else if (ce) begin
			r <= next_r;
		end
	end

	// Outputs straight from the state flops
	assign prdata = r.rdata;
	assign pready = r.rdy;
	assign pslverr = r.err;
	assign sys_reset = r.sys_rst;
	assign lvd_enable = r.lv_on;
	assign lvd_level = r.lvl;
	assign irq = r.irq_o;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence wdt_hit;
		ce && wdt_rst && !hard_rst && !lvd_rst;
	endsequence
	sequence lvd_dip;
		ce && lv_flag && !r.lv_low_d && !r.lv_mode && !any_src;
	endsequence
	sequence rst_entry;
		ce && any_src;
	endsequence
	sequence lvd_only;
		ce && lvd_rst && !hard_rst && !wdt_rst && !(done && bus_ok);
	endsequence

	pin_clear_a: assert property (ce && hard_rst |=> r.cause == 2'h0)
		else $error("cause not cleared by pin or power reset");
	read_clear_a: assert property (ce && done && bus_ok && !pwrite && !r.err
		&& paddr == rcr_pkg::OFF_CAUSE && r.rd_snap == r.cause && !any_src
		|-> prdata[1:0] == r.cause ##1 r.cause == 2'h0)
		else $error("cause read did not return and clear");
	wdt_set_a: assert property (wdt_hit |=> r.cause[1]
		&& r.cause[0] == $past(r.cause[0]))
		else $error("watchdog flag not set alone");
	lvd_bit_a: assert property (ce && lvd_rst && !hard_rst
		|=> r.cause[0])
		else $error("low-voltage flag not at bit zero");
	flag_cause_a: assert property ($rose(r.cause[1])
		|-> $past(wdt_rst))
		else $error("watchdog flag set without its source");
	keep_lv_a: assert property (ce && lvd_rst && !hard_rst && !wdt_rst
		|=> {r.lv_on, r.lvl} == $past({r.lv_on, r.lvl}))
		else $error("detector setup lost on its own reset");
	wdt_lv_a: assert property (wdt_hit
		|=> !r.lv_on && !r.lv_mode && r.lvl == 4'h0)
		else $error("detector setup kept over watchdog reset");
	poc_hold_a: assert property (rst_entry
		|=> sys_reset && r.phase == rcr_pkg::RCR_HOLD)
		else $error("reset not asserted for a source");
	release_a: assert property ($fell(sys_reset)
		|-> $past(r.stab) == rcr_pkg::STAB_CYC - 6'h01)
		else $error("reset released before stabilisation");
	lvd_irq_a: assert property (lvd_dip |=> r.irqf[0])
		else $error("low supply did not raise interrupt");
	lvl_range_a: assert property (r.lvl <= rcr_pkg::LVL_MAX)
		else $error("illegal detection level stored");
	hold_a: assert property (ce && r.sys_rst && !any_src
		|=> {r.cause, r.lv_on, r.lvl, r.mask} ==
		$past({r.cause, r.lv_on, r.lvl, r.mask}))
		else $error("state changed during reset wait");
	standby_a: assert property (ce && standby && !any_src
		|=> {r.mask, r.edge_mode, r.lvl} ==
		$past({r.mask, r.edge_mode, r.lvl}))
		else $error("state changed in standby");
	init_a: assert property (rst_entry |=> r.irqf == 8'h00
		&& r.mask == 8'hff && r.edge_mode == 8'h00)
		else $error("interrupt registers not initialised");
	// Same-cycle read-clears are kept out of the flag checks below
	lvd_wdt_keep_a: assert property (lvd_only
		|=> r.cause[0] && r.cause[1] == $past(r.cause[1]))
		else $error("low-voltage reset disturbed the watchdog flag");
	keep_flags_a: assert property (ce && (wdt_rst || lvd_rst)
		&& !hard_rst && !(done && bus_ok)
		|=> (r.cause & $past(r.cause)) == $past(r.cause))
		else $error("cause flags lost on an internal reset");
	pin_lv_a: assert property (ce && hard_rst
		|=> !r.lv_on && !r.lv_mode && r.lvl == 4'h0)
		else $error("detector setup kept over pin or power reset");
	standby_lvd_a: assert property (ce && standby && lvd_rst
		|=> sys_reset)
		else $error("detector reset lost in standby");
	ctl_set_a: assert property (ce && done && bus_ok && !r.err
		&& pwrite && paddr == rcr_pkg::OFF_CTL_SET && !any_src
		&& pwdata[rcr_pkg::CTL_ON_BIT] |=> r.lv_on)
		else $error("bit-wise set of detector enable lost");
	lvl_keep_a: assert property (ce && done && bus_ok && !r.err
		&& pwrite && paddr == rcr_pkg::OFF_LVL && !any_src
		&& pwdata[3:0] > rcr_pkg::LVL_MAX |=> r.lvl == $past(r.lvl))
		else $error("prohibited level code was stored");
	standby_ctl_a: assert property (ce && standby && !any_src
		|=> {r.lv_on, r.lv_mode} == $past({r.lv_on, r.lv_mode}))
		else $error("detector control changed in standby");

endmodule : rcr_top
`default_nettype wire

// *** tb.sv ***
// Purpose: Self-checking bench for the reset cause recorder
// Assumes: Bus effects only once sys_reset is low; ce dips once
// Notes: Random levels and edge bytes come from a fixed-seed xorshift
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, slv, sys_reset, lvd_enable, irq;
	logic pin_reset_n = 1'b1, poc_below = 1'b0, lvd_below = 1'b0;
	logic wdt_overflow = 1'b0, standby = 1'b0;
	logic [3:0] lvd_level, lvl, v;
	logic [31:0] seed = 32'hccd29544;
	int n_errors = 0, checks = 0, cyc = 0;

	rcr_top i_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_reset_n(pin_reset_n), .poc_below(poc_below),
		.lvd_below(lvd_below), .wdt_overflow(wdt_overflow),
		.standby(standby), .sys_reset(sys_reset), .lvd_enable(lvd_enable),
		.lvd_level(lvd_level), .irq(irq));

	// 50 ns period
	always #25 pclk = ~pclk;

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Codes above nine leave the level untouched
	function automatic logic [3:0] exp_lvl(logic [3:0] old, logic [3:0] nw);
		return (nw <= rcr_pkg::LVL_MAX) ? nw : old;
	endfunction : exp_lvl

	task automatic give_verdict();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Ends once pready is sampled high; the hang guard covers a stuck bus
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask : rc

	// Bounded wait for the internal reset to reach a level
	task automatic wait_sr(input logic val);
		int n;
		n = 0;
		while (sys_reset !== val && n < 200) begin
			@(posedge pclk);
			n++;
		end
		chk({31'h0, sys_reset}, {31'h0, val});
	endtask : wait_sr

	task automatic wdt_pulse();
		@(posedge pclk);
		wdt_overflow <= 1'b1;
		@(posedge pclk);
		wdt_overflow <= 1'b0;
		wait_sr(1'b1);
		wait_sr(1'b0);
	endtask : wdt_pulse

	// Hang guard, far above the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 30000) begin
			n_errors++;
			give_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		wait_sr(1'b0);
		// Values after the power-up reset
		rc(rcr_pkg::OFF_CAUSE, 32'h0);
		rc(rcr_pkg::OFF_MASK, 32'hff);
		rc(rcr_pkg::OFF_IRQF, 32'h0);
		rc(rcr_pkg::OFF_EDGE, 32'h0);
		rc(rcr_pkg::OFF_CTL, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, slv}, 32'h1);
		// Level select, corners then random codes
		lvl = 4'h0;
		for (int i = 0; i < 12; i++) begin
			v = 4'(xs());
			if (i == 0) v = 4'h9;
			if (i == 1) v = 4'ha;
			wr(rcr_pkg::OFF_LVL, {28'h0, v});
			lvl = exp_lvl(lvl, v);
			rc(rcr_pkg::OFF_LVL, {28'h0, lvl});
			chk({28'h0, lvd_level}, {28'h0, lvl});
		end
		v = 4'(xs());
		wr(rcr_pkg::OFF_EDGE, {24'h0, seed[7:0]});
		rc(rcr_pkg::OFF_EDGE, {24'h0, seed[7:0]});
		// Bit-wise control writes through the set and clear aliases
		wr(rcr_pkg::OFF_CTL_SET, 32'h80);
		rc(rcr_pkg::OFF_CTL, 32'h80);
		chk({31'h0, lvd_enable}, 32'h1);
		wr(rcr_pkg::OFF_CTL_SET, 32'h02);
		rc(rcr_pkg::OFF_CTL, 32'h82);
		wr(rcr_pkg::OFF_CTL_CLR, 32'h02);
		rc(rcr_pkg::OFF_CTL, 32'h80);
		// Writes in standby must not land
		@(posedge pclk);
		standby <= 1'b1;
		wr(rcr_pkg::OFF_LVL, {28'h0, (lvl == 4'h0) ? 4'h1 : 4'h0});
		standby <= 1'b0;
		rc(rcr_pkg::OFF_LVL, {28'h0, lvl});
		// Interrupt mode; the detector still fires in standby
		wr(rcr_pkg::OFF_MASK, 32'hfe);
		@(posedge pclk);
		standby <= 1'b1;
		lvd_below <= 1'b1;
		repeat (6) @(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		chk({31'h0, sys_reset}, 32'h0);
		standby <= 1'b0;
		rc(rcr_pkg::OFF_CTL, 32'h81);
		wr(rcr_pkg::OFF_MASK, 32'hff);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		lvd_below <= 1'b0;
		repeat (6) @(posedge pclk);
		rc(rcr_pkg::OFF_IRQF, 32'h3);
		wr(rcr_pkg::OFF_IRQF, 32'h3);
		rc(rcr_pkg::OFF_IRQF, 32'h0);
		// Watchdog reset clears detector setup, marks its own flag
		wdt_pulse();
		rc(rcr_pkg::OFF_CTL, 32'h0);
		rc(rcr_pkg::OFF_LVL, 32'h0);
		rc(rcr_pkg::OFF_MASK, 32'hff);
		rc(rcr_pkg::OFF_CAUSE, 32'h2);
		rc(rcr_pkg::OFF_CAUSE, 32'h0);
		// Low-voltage reset keeps the watchdog flag and its own setup
		wdt_pulse();
		wr(rcr_pkg::OFF_LVL, 32'h3);
		wr(rcr_pkg::OFF_CTL, 32'h82);
		@(posedge pclk);
		standby <= 1'b1;
		lvd_below <= 1'b1;
		wait_sr(1'b1);
		standby <= 1'b0;
		lvd_below <= 1'b0;
		wait_sr(1'b0);
		rc(rcr_pkg::OFF_CTL, 32'h82);
		rc(rcr_pkg::OFF_LVL, 32'h3);
		rc(rcr_pkg::OFF_CAUSE, 32'h3);
		wr(rcr_pkg::OFF_CTL, 32'h0);
		// Pin reset clears the flags
		wdt_pulse();
		pin_reset_n <= 1'b0;
		wait_sr(1'b1);
		repeat (4) @(posedge pclk);
		pin_reset_n <= 1'b1;
		wait_sr(1'b0);
		rc(rcr_pkg::OFF_CAUSE, 32'h0);
		// A watchdog pulse while frozen must leave no trace
		@(posedge pclk);
		ce <= 1'b0;
		wdt_overflow <= 1'b1;
		@(posedge pclk);
		wdt_overflow <= 1'b0;
		@(posedge pclk);
		ce <= 1'b1;
		chk({31'h0, sys_reset}, 32'h0);
		rc(rcr_pkg::OFF_CAUSE, 32'h0);
		// Supply-low reset holds while below, then clears the flags
		wdt_pulse();
		poc_below <= 1'b1;
		wait_sr(1'b1);
		repeat (60) @(posedge pclk);
		chk({31'h0, sys_reset}, 32'h1);
		poc_below <= 1'b0;
		wait_sr(1'b0);
		rc(rcr_pkg::OFF_CAUSE, 32'h0);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
